// [core/reset_source_sequencer.sv]
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "rst_seq_regs.svh"
module reset_source_sequencer
  import rst_seq_pkg::*;
#(
  parameter int unsigned WARMUP_CYC = `WARMUP_CYC_DEF
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire avm_req_t    avm_req,
  output avm_rsp_t         avm_rsp,
  input  wire logic        reset_pin,
  input  wire supply_t     supply_raw,
  input  wire logic        wdt_overflow,
  input  wire logic        rom_dump_req,
  output logic             sys_reset,
  output logic             core_run,
  output logic [9:0]       pc_start,
  output logic             shared_input_pin_option,
  output logic             rom_dump_allow,
  output logic [2:0]       fcpu_div_sel
);

  typedef struct packed {
    logic [1:0]  pin_sync;
    logic        pin_prev;
    supply_t     sup_s1;
    supply_t     sup_s2;
    boot_state_t state;
    logic [15:0] count;
    logic [1:0]  cause;
    logic        lvd_high_ind;
    logic        lvd_mid_ind;
    logic [2:0]  alu_flags;
    options_t    opt;
    logic        opt_locked;
    avm_rsp_t    rsp;
    logic        rsp_pending;
    logic        sys_reset;
    logic        core_run;
    logic        pin_input;
    logic        dump_allow;
    logic [2:0]  div_sel;
  } state_t;

  state_t cur_r;
  state_t cur_nxt;

  localparam logic [15:0] PWR_CNT  = 16'(`PWR_STABLE_CYC);
  localparam logic [15:0] INIT_CNT = 16'(`INIT_CYC);
  localparam logic [15:0] WARM_CNT = 16'(WARMUP_CYC);

  // reset-state value; options register starts at plain defaults
  function automatic state_t reset_value();
    state_t v;
    v             = '0;
    v.pin_sync    = 2'h3;
    v.pin_prev    = 1'b1;
    v.state       = st_power;
    v.cause       = `CAUSE_POR;
    v.opt         = options_t'(`OPT_RESET);
    v.rsp.waitrequest = 1'b1;
    v.sys_reset   = 1'b1;
    return v;
  endfunction : reset_value

  logic pin_fall;
  logic bo_trip;
  logic pin_low;
  logic src_reset;
  logic psf_hit;
  logic opt_hit;
  logic [7:0] psf_val;

  always_comb begin
    pin_low  = cur_r.opt.reset_pin_en && !cur_r.pin_sync[1];
    pin_fall = cur_r.opt.reset_pin_en && cur_r.pin_prev && !cur_r.pin_sync[1];
    // brown-out threshold follows the detector option
    bo_trip  = (cur_r.opt.lvd_level == lvd_high) ? cur_r.sup_s2.below_2v4
                                                 : cur_r.sup_s2.below_2v0;
    src_reset = pin_fall || bo_trip || wdt_overflow || !cur_r.sup_s2.supply_up;
    psf_hit  = (avm_req.address == `PSF_ADDR);
    opt_hit  = (avm_req.address == `OPT_ADDR);
    psf_val  = {cur_r.cause, cur_r.lvd_high_ind, cur_r.lvd_mid_ind, 1'b0, cur_r.alu_flags};
  end

  // one process computes the whole next state
  always_comb begin
    cur_nxt = cur_r;
    // pin goes through two flops, only the second is looked at
    cur_nxt.pin_sync = {cur_r.pin_sync[0], reset_pin};
    cur_nxt.pin_prev = cur_r.pin_sync[1];
    cur_nxt.sup_s1   = supply_raw;
    cur_nxt.sup_s2   = cur_r.sup_s1;
    cur_nxt.count    = (cur_r.count == 16'hffff) ? cur_r.count : cur_r.count + 16'h1;

    // indicators only exist at the higher detector options
    cur_nxt.lvd_mid_ind  = (cur_r.opt.lvd_level != lvd_low) && cur_r.sup_s2.below_2v4;
    cur_nxt.lvd_high_ind = (cur_r.opt.lvd_level == lvd_high) && cur_r.sup_s2.below_3v6;

    // boot sequence
    case (cur_r.state)
      st_power: begin
        // wait until supply has been steady long enough
        if (!cur_r.sup_s2.supply_up) begin
          cur_nxt.count = '0;
        end else if (cur_r.count >= PWR_CNT) begin
          cur_nxt.state = st_pin;
          cur_nxt.count = '0;
        end
      end
      st_pin: begin
        if (!pin_low) begin
          cur_nxt.state = st_init;
          cur_nxt.count = '0;
        end
      end
      st_init: begin
        if (cur_r.count >= INIT_CNT) begin
          cur_nxt.state = st_warmup;
          cur_nxt.count = '0;
        end
      end
      st_warmup: begin
        if (cur_r.count >= WARM_CNT) begin
          cur_nxt.state = st_run;
        end
      end
      st_run: begin
        cur_nxt.state = st_run;
      end
      default: begin
        cur_nxt.state = st_power;
      end
    endcase

    // any source restarts the sequence; later lines decide the cause
    if (src_reset) begin
      cur_nxt.count     = '0;
      cur_nxt.alu_flags = '0;
      cur_nxt.state     = cur_r.sup_s2.supply_up ? st_pin : st_power;
      if (wdt_overflow) cur_nxt.cause = `CAUSE_WDT;
      if (pin_fall) cur_nxt.cause = `CAUSE_EXT;
      if (bo_trip || !cur_r.sup_s2.supply_up) begin
        cur_nxt.cause        = `CAUSE_POR;
        cur_nxt.lvd_mid_ind  = 1'b0;
        cur_nxt.lvd_high_ind = 1'b0;
      end
    end else if (cur_r.state == st_pin && pin_low) begin
      cur_nxt.cause = `CAUSE_EXT;
    end

    // avalon slave: one wait cycle, then answer
    cur_nxt.rsp.waitrequest = 1'b1;
    cur_nxt.rsp_pending     = 1'b0;
    if ((avm_req.read || avm_req.write) && !cur_r.rsp_pending) begin
      cur_nxt.rsp_pending     = 1'b1;
      cur_nxt.rsp.waitrequest = 1'b0;
      cur_nxt.rsp.readdata    = '0;
      if (avm_req.read && psf_hit) cur_nxt.rsp.readdata = {24'h0, psf_val};
      if (avm_req.read && opt_hit) cur_nxt.rsp.readdata = {23'h0, cur_r.opt_locked, cur_r.opt};
      if (avm_req.write && psf_hit && !src_reset) begin
        // lvd bits are sensor driven and ignore writes
        cur_nxt.cause     = avm_req.writedata[`PSF_CAUSE_HI:`PSF_CAUSE_LO];
        cur_nxt.alu_flags = avm_req.writedata[`PSF_C:`PSF_Z];
      end
      // options stay writable until a write sets bit 8, then frozen like fuses
      if (avm_req.write && opt_hit && !cur_r.opt_locked) begin
        cur_nxt.opt        = options_t'(avm_req.writedata[7:0]);
        cur_nxt.opt_locked = avm_req.writedata[8];
      end
    end

    // outputs
    cur_nxt.core_run   = (cur_nxt.state == st_run);
    cur_nxt.sys_reset  = !cur_nxt.core_run;
    cur_nxt.pin_input  = !cur_r.opt.reset_pin_en && cur_r.pin_sync[1];
    cur_nxt.dump_allow = rom_dump_req && !cur_r.opt.security_en;
    // clamp to divide by 4 while filtering noise
    if (cur_r.opt.noise_filter_en && cur_r.opt.fcpu_sel < 3'd2) begin
      cur_nxt.div_sel = 3'd2;
    end else if (cur_r.opt.fcpu_sel > 3'd4) begin
      cur_nxt.div_sel = 3'd4;
    end else begin
      cur_nxt.div_sel = cur_r.opt.fcpu_sel;
    end
  end

  // single state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_r <= reset_value();
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign avm_rsp                 = cur_r.rsp;
  assign sys_reset               = cur_r.sys_reset;
  assign core_run                = cur_r.core_run;
  assign pc_start                = 10'h000;      // fetch always restarts at zero
  assign shared_input_pin_option = cur_r.pin_input;
  assign rom_dump_allow          = cur_r.dump_allow;
  assign fcpu_div_sel            = cur_r.div_sel;

endmodule : reset_source_sequencer

// [core/rst_seq_pkg.sv]
package rst_seq_pkg;
  // boot sequence, gray coded along the normal path
  typedef enum logic [2:0] {
    st_power  = 3'b000,
    st_pin    = 3'b001,
    st_init   = 3'b011,
    st_warmup = 3'b010,
    st_run    = 3'b110
  } boot_state_t;

  typedef enum logic [1:0] {
    lvd_low  = 2'h0,
    lvd_mid  = 2'h1,
    lvd_high = 2'h2
  } lvd_level_t;

  // fixed-at-programming options
  typedef struct packed {
    logic       reset_pin_en;     // 1: external reset, 0: general input
    logic       security_en;
    logic       noise_filter_en;
    lvd_level_t lvd_level;
    logic [2:0] fcpu_sel;         // 0:/1 1:/2 2:/4 3:/8 4:/16
  } options_t;

  // avalon-mm slave request and answer
  typedef struct packed {
    logic [9:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avm_rsp_t;

  // analog sensors, raw; the core syncs them through two flops (sup_s1, sup_s2)
  typedef struct packed {
    logic supply_up;
    logic below_2v0;
    logic below_2v4;
    logic below_3v6;
  } supply_t;
endpackage : rst_seq_pkg

// [core/rst_seq_regs.svh]
`ifndef RST_SEQ_REGS_SVH
`define RST_SEQ_REGS_SVH
// register offset, byte address on the avalon bus
`define PSF_OFFSET        8'h86
`define PSF_ADDR          10'h218
// option register of our own
`define OPT_ADDR          10'h000
// field positions of program_status_flags
`define PSF_CAUSE_HI      7
`define PSF_CAUSE_LO      6
`define PSF_LVD_HIGH      5
`define PSF_LVD_MID       4
`define PSF_C             2
`define PSF_DC            1
`define PSF_Z             0
// reset cause encodings
`define CAUSE_WDT         2'h0
`define CAUSE_POR         2'h2
`define CAUSE_EXT         2'h3
// timing counts, 100 MHz system clock
`define CLK_PERIOD_NS     10
`define PWR_STABLE_NS     1000
`define PWR_STABLE_CYC    ((`PWR_STABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WARMUP_CYC_DEF    2048
`define INIT_CYC          4
// option reset values
`define OPT_RESET         8'h08
`endif

// [tb/far_side_model.sv]
`timescale 1ns/10ps
module far_side_model (
  input wire logic clock,
  input wire logic pin_hold,
  input wire logic wdt_miss,
  output logic     reset_pin,
  output logic     wdt_overflow
);
  logic miss_d = 1'b0;
  // pin stays high unless a scenario holds it low
  assign reset_pin = !pin_hold;
  // software keeps clearing the counter, so overflow only when a miss is ordered
  initial wdt_overflow = 1'b0;
  always @(posedge clock) begin
    wdt_overflow <= wdt_miss && !miss_d;
    miss_d <= wdt_miss;
  end
endmodule : far_side_model

// [tb/rst_seq_checker_properties.sv]
`timescale 1ns/10ps
module rst_seq_checker
  import rst_seq_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire avm_req_t   avm_req,
  input wire avm_rsp_t   avm_rsp,
  input wire supply_t    supply_raw,
  input wire logic       wdt_overflow,
  input wire logic       rom_dump_req,
  input wire logic       sys_reset,
  input wire logic       core_run,
  input wire logic [9:0] pc_start,
  input wire logic       rom_dump_allow,
  input wire logic [2:0] fcpu_div_sel
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // fetch address never moves off zero
  property p_pc; pc_start == 10'h000; endproperty
  a_pc: assert property (p_pc) else $error("start address not zero");
  property p_run; core_run |-> !sys_reset; endproperty
  a_run: assert property (p_run) else $error("core runs in reset");
  // answer lasts exactly one cycle
  property p_wr; !avm_rsp.waitrequest |=> avm_rsp.waitrequest; endproperty
  a_wr: assert property (p_wr) else $error("answer too long");
  property p_ans; $rose(avm_req.read || avm_req.write) |=> !avm_rsp.waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer after one cycle");
  property p_dump; rom_dump_allow |-> $past(rom_dump_req); endproperty
  a_dump: assert property (p_dump) else $error("dump allowed without request");
  property p_fcpu; fcpu_div_sel <= 3'h4; endproperty
  a_fcpu: assert property (p_fcpu) else $error("divider out of range");
  property p_wdt; wdt_overflow |=> sys_reset; endproperty
  a_wdt: assert property (p_wdt) else $error("overflow did not reset");
  // the sync chain may take up to four edges to show a supply loss
  property p_supply; !supply_raw.supply_up |-> ##[1:4] sys_reset; endproperty
  a_supply: assert property (p_supply) else $error("no reset without supply");
  property p_boot; $rose(core_run) |-> $fell(sys_reset); endproperty
  a_boot: assert property (p_boot) else $error("run without leaving reset");
  c_run: cover property ($rose(core_run));
  c_wdt: cover property (wdt_overflow);
  c_rd: cover property (!avm_rsp.waitrequest);
endmodule : rst_seq_checker
bind reset_source_sequencer rst_seq_checker u_chk (.clock, .rst, .avm_req, .avm_rsp,
  .supply_raw, .wdt_overflow, .rom_dump_req, .sys_reset, .core_run, .pc_start,
  .rom_dump_allow, .fcpu_div_sel);

// [tb/tb_reset_source_sequencer.sv]
`timescale 1ns/10ps
`include "rst_seq_regs.svh"
module tb_reset_source_sequencer
  import rst_seq_pkg::*;
;
  logic        clock = 0, rst = 1, rom_dump_req = 1, pin_hold = 0, wdt_miss = 0;
  logic        reset_pin, wdt_overflow, sys_reset, core_run, shared_pin, rom_dump_allow;
  logic [9:0]  pc;
  logic [2:0]  fdiv;
  logic [31:0] q;
  avm_req_t    req = '0;
  avm_rsp_t    rsp;
  supply_t     sup = '0;
  int          error_cnt = 0, total_checks = 0, n;
  always #5 clock = ~clock;
  reset_source_sequencer #(.WARMUP_CYC(16)) uut (.clock, .rst, .avm_req(req), .avm_rsp(rsp),
    .reset_pin, .supply_raw(sup), .wdt_overflow, .rom_dump_req, .sys_reset, .core_run,
    .pc_start(pc), .shared_input_pin_option(shared_pin), .rom_dump_allow, .fcpu_div_sel(fdiv));
  far_side_model u_far (.clock, .pin_hold, .wdt_miss, .reset_pin, .wdt_overflow);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // request held until waitrequest is sampled low, then released
  // no cycle count is assumed here: only the watchdog ends a wait that never answers
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{a, !w, w, d};
    do begin @(posedge clock); end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req <= '0;
  endtask : bus
  task automatic wait_for(input bit run);
    n = 0;
    do begin @(posedge clock); n++; end
    while ((run ? core_run : sys_reset) !== 1'b1);
  endtask : wait_for
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // a hang is far beyond the roughly 300 cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (10) @(posedge clock);
    chk("held", sys_reset, 1);
    sup.supply_up <= 1'b1;
    wait_for(1);
    chk("boot length", n >= 120, 1);
    chk("pc", pc, 0);
    bus(0, `PSF_ADDR, 0); chk("cause", q, 32'h80);
    bus(0, `OPT_ADDR, 0); chk("options", q, 32'h08);
    bus(0, 10'h100, 0); chk("unmapped", q, 0);
    chk("dump open", rom_dump_allow, 1);
    $display("test boot done");
    bus(1, `PSF_ADDR, 32'hff); bus(0, `PSF_ADDR, 0); chk("psf", q, 32'hc7);
    sup.below_2v4 <= 1'b1;
    repeat (4) @(posedge clock);
    bus(0, `PSF_ADDR, 0); chk("mid flag", q, 32'hd7);
    sup.below_2v4 <= 1'b0;
    bus(1, `OPT_ADDR, 32'he8);
    repeat (3) @(posedge clock);
    chk("dump shut", rom_dump_allow, 0);
    chk("filter", fdiv, 3'h2);
    $display("test registers done");
    pin_hold <= 1'b1;
    wait_for(0);
    repeat (20) @(posedge clock);
    chk("pin hold", sys_reset, 1);
    chk("halted", core_run, 0);
    pin_hold <= 1'b0;
    wait_for(1);
    bus(0, `PSF_ADDR, 0); chk("pin cause", q, 32'hc0);
    wdt_miss <= 1'b1;
    @(posedge clock);
    wdt_miss <= 1'b0;
    wait_for(0);
    wait_for(1);
    bus(0, `PSF_ADDR, 0); chk("wdt cause", q, 32'h00);
    sup.below_2v0 <= 1'b1;
    wait_for(0);
    repeat (5) @(posedge clock);
    sup.below_2v0 <= 1'b0;
    wait_for(1);
    bus(0, `PSF_ADDR, 0); chk("lvd cause", q, 32'h80);
    $display("test sources done");
    bus(1, `OPT_ADDR, 32'h28);
    pin_hold <= 1'b1;
    repeat (10) @(posedge clock);
    chk("pin ignored", sys_reset, 0);
    chk("pin low", shared_pin, 0);
    chk("filter", fdiv, 3'h2);
    pin_hold <= 1'b0;
    repeat (5) @(posedge clock);
    chk("pin high", shared_pin, 1);
    bus(1, `OPT_ADDR, 32'h08);
    repeat (3) @(posedge clock);
    chk("no filter", fdiv, 3'h0);
    $display("test pin option done");
    stop_test();
  end
endmodule : tb_reset_source_sequencer
